// ===== level_qual.sv
// occurrence and duration qualifier for the active level
`timescale 1ns/1ns
module level_qual (
    input wire logic clk,
    input wire logic rst,
    input wire logic clear,
    input wire logic tick,
    input wire trig_seq_pkg::qual_mode_type mode,
    input wire logic consec,
    input wire logic hit,
    input wire logic [15:0] limit,
    output logic done
);
    logic [15:0] cnt_r;
    wire logic [15:0] lim = (limit == 16'h0000) ? 16'h0001 : limit;
    wire logic [15:0] cnt_inc = cnt_r + 16'h0001;

    always_comb begin
        case (mode)
            trig_seq_pkg::QM_OCCURS: done = hit && cnt_inc >= lim;
            trig_seq_pkg::QM_GT: done = hit && cnt_inc >= lim;
            trig_seq_pkg::QM_LT: done = !hit && cnt_r != 16'h0000 && cnt_r <= lim;
            default: done = hit;
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst || clear) begin
            cnt_r <= 16'h0000;
        end else if (tick) begin
            if (hit) begin
                cnt_r <= (cnt_r == 16'hFFFF) ? cnt_r : cnt_inc;
            end else if (consec || mode == trig_seq_pkg::QM_GT || mode == trig_seq_pkg::QM_LT) begin
                cnt_r <= 16'h0000;
            end
        end
    end
endmodule

// ===== sample_source.sv
// probed target stream and acquisition memory around the sequencer
`timescale 1ns/1ns
module sample_source (
    input wire logic clk,
    output logic sample_valid,
    output logic [31:0] sample_data,
    input wire logic store_valid,
    input wire logic [31:0] store_data,
    input wire logic trigger
);
    int trig_count;
    int store_count;
    logic [31:0] last_store;
    initial begin
        sample_valid = 1'b0;
        sample_data = 32'h0000_0000;
        trig_count = 0;
        store_count = 0;
        last_store = 32'h0000_0000;
    end
    always @(posedge clk) begin
        if (trigger === 1'b1) begin
            trig_count++;
        end
        if (store_valid === 1'b1) begin
            store_count++;
            last_store = store_data;
        end
    end
    task automatic clear();
        trig_count = 0;
        store_count = 0;
    endtask
    // one sample per three cycles keeps the entry cycle free and lets the counts settle
    task automatic send(input logic [31:0] d);
        @(posedge clk);
        sample_valid <= 1'b1;
        sample_data <= d;
        @(posedge clk);
        sample_valid <= 1'b0;
        sample_data <= ~d;
        @(posedge clk);
        #1;
    endtask
endmodule

// ===== seq_timer.sv
// one global timer steered by level-entry commands
`timescale 1ns/1ns
module seq_timer (
    input wire logic clk,
    input wire logic rst,
    input wire logic clear,
    input wire logic apply,
    input wire trig_seq_pkg::timer_ctl_type ctl,
    input wire logic tick,
    input wire logic [31:0] interval,
    output logic expired
);
    logic running_r;
    logic [31:0] cnt_r;
    wire logic at_end = (cnt_r + 32'h0000_0001) >= interval;

    always_ff @(posedge clk) begin
        if (rst || clear) begin
            running_r <= 1'b0;
            cnt_r <= 32'h0000_0000;
            expired <= 1'b0;
        end else if (apply && ctl != trig_seq_pkg::TC_OFF) begin
            case (ctl)
                trig_seq_pkg::TC_START: begin
                    running_r <= 1'b1;
                    cnt_r <= 32'h0000_0000;
                    expired <= 1'b0;
                end
                trig_seq_pkg::TC_STOP: begin
                    running_r <= 1'b0;
                    cnt_r <= 32'h0000_0000;
                    expired <= 1'b0;
                end
                trig_seq_pkg::TC_PAUSE: running_r <= 1'b0;
                trig_seq_pkg::TC_CONT: running_r <= !expired;
                default: running_r <= running_r;
            endcase
        end else if (running_r && tick) begin
            if (at_end) begin
                expired <= 1'b1;
                running_r <= 1'b0;
                cnt_r <= 32'h0000_0000;
            end else begin
                cnt_r <= cnt_r + 32'h0000_0001;
            end
        end
    end
endmodule

// ===== tb_trig_seq.sv
// self-checking bench for the trigger sequencer
`timescale 1ns/1ns
module tb_trig_seq;
    logic clk;
    logic rst;
    logic [11:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
    logic [31:0] rdata;
    logic sample_valid;
    logic [31:0] sample_data;
    logic arm_in;
    logic store_valid;
    logic [31:0] store_data;
    logic trigger;
    logic [3:0] level;
    logic [31:0] rv;
    int errors;
    int total_checks;
    // secondary term codes: negated true never fires, plain true always fires
    localparam logic [5:0] NEVER = 6'h31;
    localparam logic [5:0] ALWAYS = 6'h11;
    logic [7:0] occ_data[6] = '{8'h55, 8'h55, 8'hAA, 8'h55, 8'h55, 8'h55};
    logic [3:0] occ_lvl[6] = '{4'h0, 4'h0, 4'h0, 4'h0, 4'h0, 4'h1};
    logic [31:0] exp_store[3] = '{32'h0000_0002, 32'h0000_0000, 32'h0000_0001};
    trig_seq dut (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
        .sample_valid(sample_valid), .sample_data(sample_data), .arm_in(arm_in), .store_valid(store_valid),
        .store_data(store_data), .trigger(trigger), .level(level));
    sample_source src (.clk(clk), .sample_valid(sample_valid), .sample_data(sample_data),
        .store_valid(store_valid), .store_data(store_data), .trigger(trigger));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            errors++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic final_report();
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic wreg(input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rreg(input logic [11:0] a, output logic [31:0] d);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        d = rdata;
    endtask
    function automatic logic [31:0] w0(logic [4:0] a, logic [5:0] s, logic [3:0] tgt, logic [1:0] mode,
        logic [1:0] stm, logic trig);
        return {5'h00, trig, stm, mode, tgt, s, 6'h11, 1'b0, a};
    endfunction
    function automatic logic [31:0] w1(logic [15:0] cnt, logic [2:0] t0);
        return {5'h00, 5'h00, 3'h0, t0, cnt};
    endfunction
    task automatic lvl(input int n, input logic [31:0] a, input logic [31:0] b);
        wreg(12'h100 + 12'(8 * n), a);
        wreg(12'h104 + 12'(8 * n), b);
    endtask
    // start write also clears the memory model's counters
    task automatic start();
        wreg(trig_seq_pkg::ADDR_CTRL, 32'h0000_0003);
        #1;
        src.clear();
    endtask
    initial begin
        repeat (5000) @(posedge clk);
        errors++;
        final_report();
    end
    initial begin
        rst = 1'b1;
        addr = 12'h000;
        wdata = 32'h0000_0000;
        wr = 1'b0;
        rd = 1'b0;
        arm_in = 1'b0;
        errors = 0;
        total_checks = 0;
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        for (int i = 0; i < 24; i++) begin
            rreg(12'h100 + 12'(4 * i), rv);
            check(rv, 32'h0000_0000);
        end
        rreg(trig_seq_pkg::ADDR_STATUS, rv);
        check(rv, 32'h0000_0000);
        rreg(12'hFFC, rv);
        check(rv, 32'h0000_0000);
        wreg(trig_seq_pkg::ADDR_LAST, 32'h0000_000B);
        wreg(12'h080, 32'h0000_0055);
        wreg(12'h084, 32'hFFFF_FFFF);
        wreg(12'h088, 32'h0000_00AA);
        wreg(12'h08C, 32'h0000_00FF);
        lvl(0, w0(5'h00, NEVER, 4'h0, trig_seq_pkg::QM_PLAIN, trig_seq_pkg::ST_ALL, 1'b1), 32'h0000_0000);
        start();
        src.send(32'h0000_0012);
        check(32'(src.trig_count), 32'h0000_0000);
        src.send(32'h0000_0055);
        check(32'(src.trig_count), 32'h0000_0001);
        src.send(32'h0000_0055);
        check(32'(src.trig_count), 32'h0000_0001);
        lvl(0, w0(5'h00, 6'h01, 4'h0, trig_seq_pkg::QM_OCCURS, trig_seq_pkg::ST_ALL, 1'b0), w1(16'h0003, 3'h0));
        lvl(1, w0(5'h11, NEVER, 4'h0, trig_seq_pkg::QM_PLAIN, trig_seq_pkg::ST_ALL, 1'b1), 32'h0000_0000);
        start();
        for (int i = 0; i < 6; i++) begin
            src.send({24'h000000, occ_data[i]});
            check({28'h0000000, level}, {28'h0000000, occ_lvl[i]});
        end
        src.send(32'h0000_0012);
        check(32'(src.trig_count), 32'h0000_0001);
        lvl(0, w0(5'h00, ALWAYS, 4'h5, trig_seq_pkg::QM_PLAIN, trig_seq_pkg::ST_ALL, 1'b0), 32'h0000_0000);
        start();
        src.send(32'h0000_0055);
        check({28'h0000000, level}, 32'h0000_0001);
        start();
        src.send(32'h0000_0012);
        check({28'h0000000, level}, 32'h0000_0005);
        for (int m = 0; m < 3; m++) begin
            lvl(0, w0(5'h01, NEVER, 4'h0, trig_seq_pkg::QM_PLAIN, 2'(m), 1'b0), w1(16'h0001, 3'h0));
            start();
            src.send(32'h0000_0055);
            src.send(32'h0000_0012);
            check(32'(src.store_count), exp_store[m]);
        end
        check(src.last_store, 32'h0000_0055);
        wreg(trig_seq_pkg::ADDR_TMR0, 32'h0000_0004);
        lvl(0, w0(trig_seq_pkg::TERM_TMR0, NEVER, 4'h0, trig_seq_pkg::QM_PLAIN, trig_seq_pkg::ST_ALL, 1'b1),
            w1(16'h0001, trig_seq_pkg::TC_START));
        start();
        repeat (3) src.send(32'h0000_0012);
        check(32'(src.trig_count), 32'h0000_0000);
        repeat (3) src.send(32'h0000_0012);
        check(32'(src.trig_count), 32'h0000_0001);
        lvl(0, w0(5'h00, ALWAYS, 4'h7, trig_seq_pkg::QM_GT, trig_seq_pkg::ST_ALL, 1'b1), w1(16'h0003, 3'h0));
        start();
        for (int i = 0; i < 5; i++) begin
            src.send((i == 2) ? 32'h0000_0012 : 32'h0000_0055);
            check({28'h0000000, level}, 32'h0000_0000);
        end
        check(32'(src.trig_count), 32'h0000_0000);
        repeat (2) src.send(32'h0000_0055);
        check(32'(src.trig_count), 32'h0000_0001);
        // arm term alone triggers level 0
        lvl(0, 32'h0403_1450, 32'h0000_0000);
        start();
        src.send(32'h0000_0012);
        check(32'(src.trig_count), 32'h0000_0000);
        @(posedge clk);
        arm_in <= 1'b1;
        src.send(32'h0000_0012);
        check(32'(src.trig_count), 32'h0000_0001);
        rreg(trig_seq_pkg::ADDR_STATUS, rv);
        check(rv, 32'h0000_00A0);
        wreg(trig_seq_pkg::ADDR_CTRL, 32'h0000_0004);
        arm_in <= 1'b0;
        rreg(trig_seq_pkg::ADDR_STATUS, rv);
        check(rv, 32'h0000_0020);
        // rising edge on bit 0 with pattern 0
        wreg(12'h060, 32'h0000_0001);
        lvl(0, 32'h0403_100C, 32'h0000_0000);
        start();
        src.send(32'h0000_0055);
        src.send(32'h0000_0054);
        check(32'(src.trig_count), 32'h0000_0000);
        src.send(32'h0000_0055);
        check(32'(src.trig_count), 32'h0000_0001);
        lvl(0, 32'h0443_1440, 32'h0800_0002);
        start();
        for (int i = 0; i < 4; i++) begin
            src.send((i == 1) ? 32'h0000_0012 : 32'h0000_0055);
            check(32'(src.trig_count), (i == 3) ? 32'h0000_0001 : 32'h0000_0000);
        end
        final_report();
    end
endmodule
bind trig_seq trig_seq_properties chk (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr),
    .sample_valid(sample_valid), .sample_data(sample_data), .store_valid(store_valid),
    .store_data(store_data), .trigger(trigger), .level(level));

// ===== trig_seq.sv
// trigger sequencer: term matching, level stepping, storage and trigger
`timescale 1ns/1ns
module trig_seq (
    input wire logic clk,
    input wire logic rst,
    input wire logic [11:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [31:0] rdata,
    input wire logic sample_valid,
    input wire logic [31:0] sample_data,
    input wire logic arm_in,
    output logic store_valid,
    output logic [31:0] store_data,
    output logic trigger,
    output logic [3:0] level
);
    ////////////////////////////////////////////////////////////////////////
    // register storage
    logic [31:0] pat_val [10];
    logic [31:0] pat_msk [10];
    logic [31:0] res_w [4][2];
    logic [31:0] lvl_w0 [trig_seq_pkg::LEVELS];
    logic [31:0] lvl_w1 [trig_seq_pkg::LEVELS];
    logic [31:0] tmr_int [2];
    logic [3:0] last_r;
    logic timing_r;
    logic arm_r;
    logic [31:0] prev_r;
    logic prev_ok_r;
    logic entry_r;
    logic run_start;
    trig_seq_pkg::seq_state_type state_r;
    trig_seq_pkg::seq_state_type state_nxt;
    logic [3:0] level_nxt;

    wire logic hit_ctrl = addr == trig_seq_pkg::ADDR_CTRL;
    wire logic hit_stat = addr == trig_seq_pkg::ADDR_STATUS;
    wire logic hit_t0 = addr == trig_seq_pkg::ADDR_TMR0;
    wire logic hit_t1 = addr == trig_seq_pkg::ADDR_TMR1;
    wire logic hit_last = addr == trig_seq_pkg::ADDR_LAST;
    wire logic hit_res = addr[11:6] == trig_seq_pkg::REGION_RES && addr[3] == 1'b0;
    wire logic [1:0] res_idx = addr[5:4];
    wire logic hit_pat = addr[11:7] == trig_seq_pkg::REGION_PAT && addr[6:3] < 4'hA;
    wire logic [3:0] pat_idx = addr[6:3];
    wire logic hit_lvl = addr[11:8] == trig_seq_pkg::REGION_LVL && addr[7:3] < 5'(trig_seq_pkg::LEVELS);
    wire logic [3:0] lvl_idx = addr[6:3];
    wire logic word_sel = addr[2];
    wire logic run_cmd = wr && hit_ctrl && wdata[trig_seq_pkg::CTRL_START];
    wire logic stop_cmd = wr && hit_ctrl && wdata[trig_seq_pkg::CTRL_STOP];

    always_ff @(posedge clk) begin
        if (rst) begin
            for (int i = 0; i < 10; i++) begin
                pat_val[i] <= trig_seq_pkg::RST_WORD;
                pat_msk[i] <= trig_seq_pkg::RST_WORD;
            end
            for (int i = 0; i < 4; i++) begin
                res_w[i][0] <= trig_seq_pkg::RST_WORD;
                res_w[i][1] <= trig_seq_pkg::RST_WORD;
            end
            for (int i = 0; i < trig_seq_pkg::LEVELS; i++) begin
                lvl_w0[i] <= trig_seq_pkg::RST_WORD;
                lvl_w1[i] <= trig_seq_pkg::RST_WORD;
            end
            tmr_int[0] <= trig_seq_pkg::RST_WORD;
            tmr_int[1] <= trig_seq_pkg::RST_WORD;
            last_r <= 4'h0;
            timing_r <= 1'b0;
        end else if (wr) begin
            if (hit_ctrl) begin
                timing_r <= wdata[trig_seq_pkg::CTRL_TIMING];
            end
            if (hit_t0) begin
                tmr_int[0] <= wdata;
            end
            if (hit_t1) begin
                tmr_int[1] <= wdata;
            end
            if (hit_last) begin
                last_r <= (wdata[3:0] >= 4'(trig_seq_pkg::LEVELS)) ? 4'(trig_seq_pkg::LEVELS - 1) : wdata[3:0];
            end
            if (hit_res) begin
                res_w[res_idx][word_sel] <= wdata;
            end
            if (hit_pat && !word_sel) begin
                pat_val[pat_idx] <= wdata;
            end
            if (hit_pat && word_sel) begin
                pat_msk[pat_idx] <= wdata;
            end
            if (hit_lvl && !word_sel) begin
                lvl_w0[lvl_idx] <= wdata;
            end
            if (hit_lvl && word_sel) begin
                lvl_w1[lvl_idx] <= wdata;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // register read, answered in the next cycle
    wire logic [31:0] status_word = {24'h00_0000, state_r == trig_seq_pkg::SQ_DONE,
                                     state_r == trig_seq_pkg::SQ_RUN, arm_r, 1'b0, level};
    wire logic [31:0] rd_mux = hit_ctrl ? {30'h0000_0000, timing_r, 1'b0} :
                               hit_stat ? status_word :
                               hit_t0 ? tmr_int[0] :
                               hit_t1 ? tmr_int[1] :
                               hit_last ? {28'h000_0000, last_r} :
                               hit_res ? res_w[res_idx][word_sel] :
                               hit_pat ? (word_sel ? pat_msk[pat_idx] : pat_val[pat_idx]) :
                               hit_lvl ? (word_sel ? lvl_w1[lvl_idx] : lvl_w0[lvl_idx]) :
                               32'h0000_0000;

    always_ff @(posedge clk) begin
        if (rst) begin
            rdata <= 32'h0000_0000;
        end else if (rd) begin
            rdata <= rd_mux;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // resource terms for the current sample
    logic [31:0] term_vec;
    logic [1:0] tmr_exp;
    logic [9:0] pat_hit;
    logic [1:0] rng_hit;
    logic [1:0] edge_hit;
    wire logic [31:0] rise_bits = ~prev_r & sample_data;
    wire logic [31:0] fall_bits = prev_r & ~sample_data;

    always_comb begin
        for (int i = 0; i < 10; i++) begin
            pat_hit[i] = ((sample_data ^ pat_val[i]) & pat_msk[i]) == 32'h0000_0000;
        end
        for (int i = 0; i < 2; i++) begin
            rng_hit[i] = sample_data >= res_w[i][0] && sample_data <= res_w[i][1];
            // edges only in timing mode, ORed across channels
            edge_hit[i] = timing_r && prev_ok_r
                          && (((rise_bits & res_w[i + 2][0]) | (fall_bits & res_w[i + 2][1])) != 32'h0);
        end
        term_vec = {14'h0000, 1'b1, arm_r, tmr_exp, edge_hit, rng_hit, pat_hit};
    end

    ////////////////////////////////////////////////////////////////////////
    // active level decode
    wire logic [31:0] w0 = lvl_w0[level];
    wire logic [31:0] w1 = lvl_w1[level];
    wire trig_seq_pkg::qual_mode_type qmode = trig_seq_pkg::qual_mode_type'(w0[trig_seq_pkg::W0_MODE +: 2]);
    wire trig_seq_pkg::store_mode_type smode = trig_seq_pkg::store_mode_type'(w0[trig_seq_pkg::W0_STM +: 2]);
    wire logic [3:0] sec_tgt = w0[trig_seq_pkg::W0_TGT +: 4];
    // two terms ANDed on the same sample
    wire logic pri_hit = trig_seq_pkg::term_pick(term_vec, w0[trig_seq_pkg::W0_PA +: 5], w0[trig_seq_pkg::W0_NA])
                         && trig_seq_pkg::term_pick(term_vec, w0[trig_seq_pkg::W0_PB +: 5], w0[trig_seq_pkg::W0_NB]);
    // durations leave only the primary branch
    wire logic dur_mode = qmode == trig_seq_pkg::QM_GT || qmode == trig_seq_pkg::QM_LT;
    wire logic sec_hit = !dur_mode
                         && trig_seq_pkg::term_pick(term_vec, w0[trig_seq_pkg::W0_SEC +: 5], w0[trig_seq_pkg::W0_NS]);
    wire logic store_hit = trig_seq_pkg::term_pick(term_vec, w1[trig_seq_pkg::W1_STT +: 5], 1'b0);
    wire logic running = state_r == trig_seq_pkg::SQ_RUN;
    wire logic step = running && sample_valid && !entry_r;
    logic pri_done;

    level_qual u_qual (
        .clk(clk),
        .rst(rst),
        .clear(run_start || level_nxt != level || entry_r),
        .tick(step),
        .mode(qmode),
        .consec(w1[trig_seq_pkg::W1_CONS]),
        .hit(pri_hit),
        .limit(w1[trig_seq_pkg::W1_CNT +: 16]),
        .done(pri_done)
    );

    // two global timers, both steered on every level entry
    for (genvar t = 0; t < 2; t++) begin : g_tmr
        seq_timer u_tmr (
            .clk(clk),
            .rst(rst),
            .clear(run_start),
            .apply(entry_r && running),
            .ctl(trig_seq_pkg::timer_ctl_type'(w1[trig_seq_pkg::W1_T0 + 3 * t +: 3])),
            .tick(sample_valid),
            .interval(tmr_int[t]),
            .expired(tmr_exp[t])
        );
    end

    ////////////////////////////////////////////////////////////////////////
    // branching; the library macros are programmed as chains of these levels
    // restart term may be given priority over the final match
    wire logic sec_first = sec_hit && w1[trig_seq_pkg::W1_SECW];
    // primary wins a tie unless restart priority is set
    wire logic take_pri = step && pri_done && !sec_first;
    // secondary branch when primary not taken
    wire logic take_sec = step && sec_hit && !take_pri;
    wire logic fire = take_pri && w0[trig_seq_pkg::W0_TRIG];
    assign run_start = run_cmd;

    always_comb begin
        level_nxt = level;
        state_nxt = state_r;
        case (state_r)
            trig_seq_pkg::SQ_IDLE: begin
                if (run_cmd) begin
                    state_nxt = trig_seq_pkg::SQ_RUN;
                end
            end
            trig_seq_pkg::SQ_RUN: begin
                if (stop_cmd) begin
                    state_nxt = trig_seq_pkg::SQ_IDLE;
                end else if (fire) begin
                    state_nxt = trig_seq_pkg::SQ_DONE;
                end else if (take_pri) begin
                    level_nxt = (level < last_r) ? level + 4'h1 : level;
                end else if (take_sec) begin
                    level_nxt = (sec_tgt <= last_r) ? sec_tgt : 4'h0;
                end
            end
            trig_seq_pkg::SQ_DONE: begin
                if (stop_cmd) begin
                    state_nxt = trig_seq_pkg::SQ_IDLE;
                end
            end
            default: state_nxt = trig_seq_pkg::SQ_IDLE;
        endcase
        // new acquisition restarts at level zero
        if (run_cmd) begin
            level_nxt = 4'h0;
            state_nxt = trig_seq_pkg::SQ_RUN;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            state_r <= trig_seq_pkg::SQ_IDLE;
            level <= 4'h0;
            entry_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            level <= level_nxt;
            // entry pulse: timers act and counters restart before evaluation
            entry_r <= run_cmd || (level_nxt != level) || take_sec;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // sample history, arm flag, storage and trigger outputs
    // first sample of a run has no history, so it may not count as an edge
    always_ff @(posedge clk) begin
        if (rst || run_cmd) begin
            prev_r <= 32'h0000_0000;
            prev_ok_r <= 1'b0;
        end else if (sample_valid) begin
            prev_r <= sample_data;
            prev_ok_r <= 1'b1;
        end
    end

    // arm flag sticky per run; an arm seen with the start write still counts
    always_ff @(posedge clk) begin
        if (rst) begin
            arm_r <= 1'b0;
        end else if (run_cmd) begin
            arm_r <= arm_in;
        end else begin
            arm_r <= arm_r | arm_in;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            trigger <= 1'b0;
            store_valid <= 1'b0;
            store_data <= 32'h0000_0000;
        end else begin
            trigger <= fire;
            store_data <= sample_data;
            if (state_r == trig_seq_pkg::SQ_DONE) begin
                store_valid <= sample_valid;
            end else if (running) begin
                case (smode)
                    trig_seq_pkg::ST_ALL: store_valid <= sample_valid;
                    trig_seq_pkg::ST_QUAL: store_valid <= sample_valid && store_hit;
                    default: store_valid <= 1'b0;
                endcase
            end else begin
                store_valid <= 1'b0;
            end
        end
    end
endmodule

// ===== trig_seq_pkg.sv
// constants, register map and helpers for the trigger sequencer
package trig_seq_pkg;
    localparam int SAMPLE_W = 32;
    localparam int LEVELS = 12;
    localparam int CNT_W = 16;
    localparam int ADDR_W = 12;
    // register map
    localparam logic [11:0] ADDR_CTRL = 12'h000;
    localparam logic [11:0] ADDR_STATUS = 12'h004;
    localparam logic [11:0] ADDR_TMR0 = 12'h008;
    localparam logic [11:0] ADDR_TMR1 = 12'h00C;
    localparam logic [11:0] ADDR_LAST = 12'h010;
    localparam logic [5:0] REGION_RES = 6'h01;
    localparam logic [4:0] REGION_PAT = 5'h01;
    localparam logic [3:0] REGION_LVL = 4'h1;
    localparam int CTRL_START = 0;
    localparam int CTRL_TIMING = 1;
    localparam int CTRL_STOP = 2;
    // level word 0 fields
    localparam int W0_PA = 0;
    localparam int W0_NA = 5;
    localparam int W0_PB = 6;
    localparam int W0_NB = 11;
    localparam int W0_SEC = 12;
    localparam int W0_NS = 17;
    localparam int W0_TGT = 18;
    localparam int W0_MODE = 22;
    localparam int W0_STM = 24;
    localparam int W0_TRIG = 26;
    // level word 1 fields
    localparam int W1_CNT = 0;
    localparam int W1_T0 = 16;
    localparam int W1_T1 = 19;
    localparam int W1_STT = 22;
    localparam int W1_CONS = 27;
    localparam int W1_SECW = 28;
    localparam logic [31:0] RST_WORD = 32'h0000_0000;
    // term indices
    localparam logic [4:0] TERM_RANGE0 = 5'h0A;
    localparam logic [4:0] TERM_EDGE0 = 5'h0C;
    localparam logic [4:0] TERM_TMR0 = 5'h0E;
    localparam logic [4:0] TERM_ARM = 5'h10;
    localparam logic [4:0] TERM_TRUE = 5'h11;
    typedef enum logic [1:0] {QM_PLAIN = 2'h0, QM_OCCURS = 2'h1, QM_GT = 2'h2, QM_LT = 2'h3} qual_mode_type;
    typedef enum logic [2:0] {TC_OFF = 3'h0, TC_START = 3'h1, TC_STOP = 3'h2, TC_PAUSE = 3'h3,
                              TC_CONT = 3'h4} timer_ctl_type;
    typedef enum logic [1:0] {ST_ALL = 2'h0, ST_NONE = 2'h1, ST_QUAL = 2'h2} store_mode_type;
    typedef enum logic [1:0] {SQ_IDLE = 2'h0, SQ_RUN = 2'h1, SQ_DONE = 2'h3} seq_state_type;

    function automatic logic term_pick(input logic [31:0] vec, input logic [4:0] sel, input logic neg);
        term_pick = vec[sel] ^ neg;
    endfunction
endpackage

// ===== trig_seq_properties.sv
// concurrent checks on the trigger sequencer ports
`timescale 1ns/1ns
module trig_seq_properties (
    input wire logic clk,
    input wire logic rst,
    input wire logic [11:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr,
    input wire logic sample_valid,
    input wire logic [31:0] sample_data,
    input wire logic store_valid,
    input wire logic [31:0] store_data,
    input wire logic trigger,
    input wire logic [3:0] level
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);
    // no trigger may appear before software has started a run
    logic started_r;
    always_ff @(posedge clk) begin
        if (rst) begin
            started_r <= 1'b0;
        end else if (wr && addr == trig_seq_pkg::ADDR_CTRL && wdata[trig_seq_pkg::CTRL_START]) begin
            started_r <= 1'b1;
        end
    end
    sequence s_trig_quiet;
        trigger && !wr ##1 !wr;
    endsequence
    property p_trig_pulse;
        trigger |=> !trigger;
    endproperty
    property p_rst_clear;
        $fell(rst) |-> level == 4'h0 && !trigger && !store_valid;
    endproperty
    property p_store_src;
        store_valid |-> $past(sample_valid) && store_data == $past(sample_data);
    endproperty
    property p_level_cause;
        !$stable(level) |-> $past(sample_valid) || $past(wr);
    endproperty
    property p_trig_cause;
        trigger |-> $past(sample_valid);
    endproperty
    property p_halt;
        s_trig_quiet |=> $stable(level) && !trigger;
    endproperty
    property p_level_max;
        level <= 4'hB;
    endproperty
    property p_start_first;
        trigger |-> started_r;
    endproperty
    a_trig_pulse: assert property (p_trig_pulse) else $error("trigger wider than one cycle");
    a_rst_clear: assert property (p_rst_clear) else $error("outputs not cleared by reset");
    a_store_src: assert property (p_store_src) else $error("stored word not the last sample");
    a_level_cause: assert property (p_level_cause) else $error("level moved without a sample");
    a_trig_cause: assert property (p_trig_cause) else $error("trigger without a deciding sample");
    a_halt: assert property (p_halt) else $error("sequencer moved after trigger");
    a_level_max: assert property (p_level_max) else $error("level index beyond last level");
    a_start_first: assert property (p_start_first) else $error("trigger before any start");
endmodule
